// File: rtl/oag_defs.svh
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH
// ----------------------------------------
// Widths
// ----------------------------------------
`define OAG_AW          16
`define OAG_DW          8
// ----------------------------------------
// Mode codes (mode input)
// ----------------------------------------
`define OAG_M_INH       4'h0
`define OAG_M_IMM       4'h1
`define OAG_M_DIR_S     4'h2
`define OAG_M_DIR_L     4'h3
`define OAG_M_IDX_0     4'h4
`define OAG_M_IDX_S     4'h5
`define OAG_M_IDX_L     4'h6
`define OAG_M_IND_S     4'h7
`define OAG_M_IND_L     4'h8
`define OAG_M_IIX_S     4'h9
`define OAG_M_IIX_L     4'hA
`define OAG_M_REL_D     4'hB
`define OAG_M_REL_I     4'hC
// ----------------------------------------
// Reset values
// ----------------------------------------
`define OAG_ADDR_RST    16'h0000
`define OAG_BYTE_RST    8'h00
`endif

// File: rtl/oag_mem_if.sv
`timescale 1ns/1ns
// ----------------------------------------
// Byte read channel between sequencer and memory port
// ----------------------------------------
interface oag_mem_if;
  logic        req;
  logic [15:0] addr;
  logic        vld;
  logic [7:0]  data;
  modport ctl (output req, output addr, input vld, input data);
  modport prt (input req, input addr, output vld, output data);
endinterface

// File: rtl/oag_mem_port.sv
`timescale 1ns/1ns
`include "oag_defs.svh"
// ----------------------------------------
// Registered memory port, one read at a time
// ----------------------------------------
module oag_mem_port (
  input  wire logic             clk,
  input  wire logic             srst,
  oag_mem_if.prt                mi,
  output logic                  mem_rd_r,
  output logic [15:0]           mem_addr_r,
  input  wire logic             mem_rvalid,
  input  wire logic [7:0]       mem_rdata
);
  logic busy_r;
  assign mi.vld  = busy_r & mem_rvalid;
  assign mi.data = mem_rdata;
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r     <= 1'b0;
      mem_rd_r   <= 1'b0;
      mem_addr_r <= `OAG_ADDR_RST;
    end else begin
      mem_rd_r <= mi.req & ~busy_r;
      if (mi.req & ~busy_r) begin
        busy_r     <= 1'b1;
        mem_addr_r <= mi.addr;
      end else if (mi.vld) begin
        busy_r <= 1'b0;
      end
    end
  end
endmodule // oag_mem_port

// File: rtl/oag_pkg.sv
package oag_pkg;
  typedef logic [3:0]  oag_mode_t;
  typedef logic [15:0] oag_addr_t;
  typedef logic [7:0]  oag_byte_t;
endpackage

// File: rtl/oag_top.sv
`timescale 1ns/1ns
`include "oag_defs.svh"
// Notes on behaviour
// - Inherent mode needs no bytes after the opcode.
// - Immediate mode reads one byte, used as operand value.
// - Short direct: one address byte, address range 00 to FF.
// - Long direct: two address bytes, whole 64 Kbyte space.
// - Indexed address is unsigned sum of chosen index and offset.
// - Indexed no offset: no extra byte, address is index alone.
// - Short indexed: one offset byte plus index, range 00 to 1FE.
// - Long indexed: two offset bytes plus index, full space.
// - Indirect: pointer read from memory at the byte after opcode.
// - Short indirect: one-byte pointer, range 00 to FF.
// - Long indirect: two-byte pointer read, full space.
// - Indirect indexed: unsigned sum of index and fetched pointer.
// - Short indirect indexed: byte pointer plus index, 00 to 1FE.
// - Short direct and indirect forms reach page zero only; all short forms take fewer cycles.
// - Read-modify-write instructions refuse long forms only.
// - Long forms reach the whole space at extra bytes and cycles.
// - Relative mode adds a signed 8-bit offset to the PC.
// - Relative indirect reads offset from memory; direct uses next byte.
module oag_top
  import oag_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             start,
  input  wire oag_pkg::oag_mode_t mode,
  input  wire logic             rmw,
  input  wire logic             idx_sel,
  input  wire oag_pkg::oag_byte_t idx_x,
  input  wire oag_pkg::oag_byte_t idx_y,
  input  wire oag_pkg::oag_addr_t pc_next,
  input  wire logic             opnd_vld,
  input  wire oag_pkg::oag_byte_t opnd_byte,
  output logic [1:0]            bytes_left_r,
  output logic                  busy_r,
  output logic                  done_r,
  output logic                  illegal_r,
  output logic                  imm_vld_r,
  output oag_pkg::oag_byte_t    imm_r,
  output oag_pkg::oag_addr_t    ea_r,
  output logic                  mem_rd_r,
  output oag_pkg::oag_addr_t    mem_addr_r,
  input  wire logic             mem_rvalid,
  input  wire oag_pkg::oag_byte_t mem_rdata
);
  import oag_pkg::*;

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [4:0] {
    OAG_IDLE = 5'b00001,
    OAG_OPND = 5'b00010,
    OAG_PHI  = 5'b00100,
    OAG_PLO  = 5'b01000,
    OAG_FIN  = 5'b10000
  } oag_state_e;

  oag_state_e st_r, st_nxt;
  oag_mode_t  mode_r;
  logic       xsel_r;
  logic [7:0] idx_r;
  logic [15:0] opw_r;
  logic [15:0] ptr_r;
  logic [15:0] pc_r;
  logic [1:0] cnt_r;

  oag_mem_if mi ();

  oag_mem_port u_port (
    .clk        (clk),
    .srst       (srst),
    .mi         (mi),
    .mem_rd_r   (mem_rd_r),
    .mem_addr_r (mem_addr_r),
    .mem_rvalid (mem_rvalid),
    .mem_rdata  (mem_rdata)
  );

  // ----------------------------------------
  // Mode decoding
  // ----------------------------------------
  function automatic logic [1:0] oag_len(input oag_mode_t m);
    unique case (m)
      `OAG_M_INH, `OAG_M_IDX_0: oag_len = 2'd0;
      `OAG_M_DIR_L, `OAG_M_IDX_L: oag_len = 2'd2;
      default: oag_len = 2'd1;
    endcase
  endfunction

  function automatic logic oag_is_long(input oag_mode_t m);
    oag_is_long = (m == `OAG_M_DIR_L) || (m == `OAG_M_IDX_L) ||
                  (m == `OAG_M_IND_L) || (m == `OAG_M_IIX_L);
  endfunction

  function automatic logic oag_is_ind(input oag_mode_t m);
    oag_is_ind = (m == `OAG_M_IND_S) || (m == `OAG_M_IND_L) ||
                 (m == `OAG_M_IIX_S) || (m == `OAG_M_IIX_L) ||
                 (m == `OAG_M_REL_I);
  endfunction

  // Codes above the table and long forms under read-modify-write refused
  wire        bad_code  = (mode > `OAG_M_REL_I);
  wire        bad_rmw   = rmw & oag_is_long(mode);
  wire        refuse    = bad_code | bad_rmw;
  wire [1:0]  len_dec   = oag_len(mode);
  wire        ind_r     = oag_is_ind(mode_r);
  wire        ptr_word  = (mode_r == `OAG_M_IND_L) | (mode_r == `OAG_M_IIX_L);
  wire        idx_mode  = (mode_r == `OAG_M_IDX_0) | (mode_r == `OAG_M_IDX_S) |
                          (mode_r == `OAG_M_IDX_L) | (mode_r == `OAG_M_IIX_S) |
                          (mode_r == `OAG_M_IIX_L);
  wire [7:0]  idx_pick  = idx_sel ? idx_y : idx_x;

  // ----------------------------------------
  // Effective address
  // ----------------------------------------
  // Pointer address is the single byte after the opcode, page zero only
  wire [15:0] ptr_addr  = {8'h00, opw_r[7:0]};
  wire [15:0] ptr_lo    = ptr_addr + 16'h0001;
  wire [15:0] base      = ind_r ? ptr_r : opw_r;
  wire [15:0] idx_add   = idx_mode ? {8'h00, idx_r} : 16'h0000;
  // Unsigned sum; short forms top out at 1FE, long ones wrap in 64K
  wire [15:0] ea_sum    = base + idx_add;
  wire [7:0]  rel_off   = ind_r ? ptr_r[7:0] : opw_r[7:0];
  wire [15:0] ea_rel    = pc_r + {{8{rel_off[7]}}, rel_off};
  wire        rel_mode  = (mode_r == `OAG_M_REL_D) | (mode_r == `OAG_M_REL_I);
  wire [15:0] ea_fin    = rel_mode ? ea_rel : ea_sum;

  assign mi.req  = (st_r == OAG_PHI) | (st_r == OAG_PLO);
  assign mi.addr = (st_r == OAG_PLO) ? ptr_lo : ptr_addr;

  wire last_opnd = opnd_vld & (cnt_r == 2'd1);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      OAG_IDLE: if (start & ~refuse) st_nxt = (len_dec == 2'd0) ? OAG_FIN : OAG_OPND;
      OAG_OPND: if (last_opnd) st_nxt = ind_r ? OAG_PHI : OAG_FIN;
      // Word pointer: high byte first, then low byte at next address
      OAG_PHI:  if (mi.vld) st_nxt = ptr_word ? OAG_PLO : OAG_FIN;
      OAG_PLO:  if (mi.vld) st_nxt = OAG_FIN;
      OAG_FIN:  st_nxt = OAG_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r         <= OAG_IDLE;
      mode_r       <= `OAG_M_INH;
      xsel_r       <= 1'b0;
      idx_r        <= `OAG_BYTE_RST;
      opw_r        <= `OAG_ADDR_RST;
      ptr_r        <= `OAG_ADDR_RST;
      pc_r         <= `OAG_ADDR_RST;
      cnt_r        <= 2'd0;
      bytes_left_r <= 2'd0;
      busy_r       <= 1'b0;
      done_r       <= 1'b0;
      illegal_r    <= 1'b0;
      imm_vld_r    <= 1'b0;
      imm_r        <= `OAG_BYTE_RST;
      ea_r         <= `OAG_ADDR_RST;
    end else begin
      st_r      <= st_nxt;
      done_r    <= 1'b0;
      imm_vld_r <= 1'b0;
      illegal_r <= (st_r == OAG_IDLE) & start & refuse;
      if ((st_r == OAG_IDLE) & start & ~refuse) begin
        mode_r       <= mode;
        xsel_r       <= idx_sel;
        idx_r        <= idx_pick;
        pc_r         <= pc_next;
        opw_r        <= `OAG_ADDR_RST;
        cnt_r        <= len_dec;
        bytes_left_r <= len_dec;
        busy_r       <= 1'b1;
      end
      if ((st_r == OAG_OPND) & opnd_vld) begin
        // Multi-byte words arrive high byte first
        opw_r        <= {opw_r[7:0], opnd_byte};
        cnt_r        <= cnt_r - 2'd1;
        bytes_left_r <= cnt_r - 2'd1;
      end
      if (mi.vld) begin
        ptr_r <= ptr_word ? {ptr_r[7:0], mi.data} : {8'h00, mi.data};
      end
      if (st_r == OAG_FIN) begin
        // Only after all pointer bytes are in
        ea_r      <= ea_fin;
        imm_r     <= opw_r[7:0];
        imm_vld_r <= (mode_r == `OAG_M_IMM);
        done_r    <= 1'b1;
        busy_r    <= 1'b0;
      end
    end
  end

endmodule // oag_top

// File: verification/oag_mem_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Byte memory, content derived from address
// ----------------------------------------
module oag_mem_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        slow,
  input  wire logic        mem_rd_r,
  input  wire logic [15:0] mem_addr_r,
  output logic             mem_rvalid,
  output logic [7:0]       mem_rdata
);
  logic [2:0] cnt_r;
  logic [7:0] val_r;
  always_ff @(posedge clk) begin
    if (srst) cnt_r <= 3'h0;
    else if (mem_rd_r) cnt_r <= slow ? 3'h4 : 3'h1;
    else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
    if (mem_rd_r) val_r <= mem_addr_r[7:0] ^ mem_addr_r[15:8] ^ 8'hA5;
  end
  assign mem_rvalid = (cnt_r == 3'h1);
  // Stale data inverted so a late sample cannot match
  assign mem_rdata = mem_rvalid ? val_r : ~val_r;
endmodule // oag_mem_model

// File: verification/oag_top_chk.sv
`timescale 1ns/1ns
`include "oag_defs.svh"
module oag_top_chk (
  input wire logic               clk,
  input wire logic               srst,
  input wire logic               start,
  input wire oag_pkg::oag_mode_t mode,
  input wire logic               rmw,
  input wire logic               opnd_vld,
  input wire logic [1:0]         bytes_left_r,
  input wire logic               busy_r,
  input wire logic               done_r,
  input wire logic               illegal_r,
  input wire oag_pkg::oag_addr_t ea_r,
  input wire logic               mem_rd_r,
  input wire oag_pkg::oag_addr_t mem_addr_r
);
  import oag_pkg::*;
  oag_mode_t mode_r;
  wire take = start && !busy_r && !done_r;
  always_ff @(posedge clk) begin
    if (srst) mode_r <= 4'h0;
    else if (take) mode_r <= mode;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_bad; take && mode > 4'hC |=> illegal_r && !busy_r; endproperty
  a_bad: assert property (p_bad) else $error("bad code accepted");
  property p_rmw; take && rmw && mode inside {`OAG_M_DIR_L, `OAG_M_IDX_L, `OAG_M_IND_L,
    `OAG_M_IIX_L} |=> illegal_r; endproperty
  a_rmw: assert property (p_rmw) else $error("long rmw accepted");
  property p_zero; take && mode inside {`OAG_M_INH, `OAG_M_IDX_0}
    |=> bytes_left_r == 2'h0 ##1 done_r; endproperty
  a_zero: assert property (p_zero) else $error("zero length wrong");
  property p_two; take && !rmw && mode inside {`OAG_M_DIR_L, `OAG_M_IDX_L}
    |=> bytes_left_r == 2'h2; endproperty
  a_two: assert property (p_two) else $error("word count wrong");
  property p_one; take && !rmw && mode inside {`OAG_M_IMM, `OAG_M_DIR_S, `OAG_M_IDX_S,
    [`OAG_M_IND_S:`OAG_M_REL_I]} |=> bytes_left_r == 2'h1; endproperty
  a_one: assert property (p_one) else $error("byte count wrong");
  property p_dec; opnd_vld && bytes_left_r != 2'h0
    |=> bytes_left_r == $past(bytes_left_r) - 2'h1; endproperty
  a_dec: assert property (p_dec) else $error("count not stepped");
  property p_page; done_r && mode_r inside {`OAG_M_DIR_S, `OAG_M_IND_S, `OAG_M_IDX_0}
    |-> ea_r[15:8] == 8'h00; endproperty
  a_page: assert property (p_page) else $error("left page zero");
  property p_sum; done_r && mode_r inside {`OAG_M_IDX_S, `OAG_M_IIX_S}
    |-> ea_r <= 16'h01FE; endproperty
  a_sum: assert property (p_sum) else $error("sum out of range");
  property p_ptr; mem_rd_r |-> mem_addr_r[15:9] == 7'h00 ##1 !done_r; endproperty
  a_ptr: assert property (p_ptr) else $error("pointer read wrong");
endmodule // oag_top_chk
bind oag_top oag_top_chk i_chk (.clk(clk), .srst(srst), .start(start), .mode(mode),
  .rmw(rmw), .opnd_vld(opnd_vld), .bytes_left_r(bytes_left_r), .busy_r(busy_r),
  .done_r(done_r), .illegal_r(illegal_r), .ea_r(ea_r), .mem_rd_r(mem_rd_r),
  .mem_addr_r(mem_addr_r));

// File: verification/oag_top_tb.sv
`timescale 1ns/1ns
`include "oag_defs.svh"
module oag_top_tb;
  import oag_pkg::*;
  logic clk, srst, start, rmw, idx_sel, opnd_vld, slow;
  logic busy_r, done_r, illegal_r, imm_vld_r, mem_rd_r, mem_rvalid;
  logic [1:0] bytes_left_r;
  oag_mode_t mode;
  oag_byte_t idx_x, idx_y, opnd_byte, imm_r, mem_rdata;
  oag_addr_t pc_next, ea_r, mem_addr_r;
  int n_mismatch, checked, cyc;
  localparam oag_byte_t B0 = 8'hF0;
  localparam oag_byte_t B1 = 8'h12;
  oag_top i_dut (.clk(clk), .srst(srst), .start(start), .mode(mode), .rmw(rmw),
    .idx_sel(idx_sel), .idx_x(idx_x), .idx_y(idx_y), .pc_next(pc_next),
    .opnd_vld(opnd_vld), .opnd_byte(opnd_byte), .bytes_left_r(bytes_left_r),
    .busy_r(busy_r), .done_r(done_r), .illegal_r(illegal_r), .imm_vld_r(imm_vld_r),
    .imm_r(imm_r), .ea_r(ea_r), .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  oag_mem_model i_mem (.clk(clk), .srst(srst), .slow(slow), .mem_rd_r(mem_rd_r),
    .mem_addr_r(mem_addr_r), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Pointer bytes follow the memory model's address hash
  function automatic oag_addr_t exp_ea(input oag_mode_t m, input oag_addr_t ix);
    oag_byte_t p = B0 ^ 8'hA5;
    oag_byte_t q = (B0 + 8'h01) ^ 8'hA5;
    case (m)
      `OAG_M_DIR_S: return {8'h00, B0};
      `OAG_M_DIR_L: return {B0, B1};
      `OAG_M_IDX_0: return ix;
      `OAG_M_IDX_S: return ix + B0;
      `OAG_M_IDX_L: return ix + {B0, B1};
      `OAG_M_IND_S: return {8'h00, p};
      `OAG_M_IND_L: return {p, q};
      `OAG_M_IIX_S: return ix + p;
      `OAG_M_IIX_L: return ix + {p, q};
      `OAG_M_REL_D: return pc_next + {{8{B0[7]}}, B0};
      default: return pc_next + {{8{p[7]}}, p};
    endcase
  endfunction
  // High byte goes first on two-byte operands
  task automatic run(input oag_mode_t m, input logic r, output logic [1:0] left,
                     output logic ill, output int k);
    @(negedge clk);
    mode = m;
    rmw = r;
    idx_sel = m[0];
    // Slow memory when mode bits 3 and 0 are both set (short indirect indexed, relative direct); modes 2, 3, 7 and 8, whose cycle counts are compared, stay fast
    slow = m[3] & m[0];
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    left = bytes_left_r;
    ill = illegal_r;
    for (k = 0; k < 20 && done_r !== 1'b1; k++) begin
      opnd_vld = (bytes_left_r != 2'h0);
      opnd_byte = (bytes_left_r == left) ? B0 : B1;
      @(negedge clk);
    end
    opnd_vld = 1'b0;
  endtask
  task automatic t_modes();
    logic [1:0] left;
    logic ill;
    int k;
    int cy[16];
    for (int m = 0; m <= 12; m++) begin
      run(oag_mode_t'(m), 1'b0, left, ill, k);
      cy[m] = k;
      chk(left, (m == 0 || m == 4) ? 16'h0 : (m == 3 || m == 6) ? 16'h2 : 16'h1);
      chk(done_r, 1'b1);
      if (m == 1) chk({imm_vld_r, imm_r}, {1'b1, B0});
      if (m > 1) chk(ea_r, exp_ea(oag_mode_t'(m), {8'h00, m[0] ? idx_y : idx_x}));
      if (m == 7 || m == 9 || m == 12) chk(mem_addr_r, {8'h00, B0});
      if (m == 8 || m == 10) chk(mem_addr_r, {8'h00, B0 + 8'h01});
    end
    chk(16'(cy[2] < cy[3]), 16'h1);
    chk(16'(cy[7] < cy[8]), 16'h1);
    $display("t_modes done");
  endtask
  task automatic t_rmw();
    logic [1:0] left;
    logic ill;
    int k;
    oag_mode_t bad[7] = '{4'h3, 4'h6, 4'h8, 4'hA, 4'hD, 4'hE, 4'hF};
    foreach (bad[i]) begin
      run(bad[i], i < 4, left, ill, k);
      chk({ill, done_r}, 2'b10);
    end
    run(`OAG_M_IDX_S, 1'b1, left, ill, k);
    chk(done_r, 1'b1);
    $display("t_rmw done");
  endtask
  // Reset while a pointer read is outstanding, then a clean long indirect
  task automatic t_reset();
    logic [1:0] left;
    logic ill;
    int k;
    @(negedge clk);
    mode = `OAG_M_IND_L;
    rmw = 1'b0;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    opnd_vld = 1'b1;
    opnd_byte = B0;
    @(negedge clk);
    opnd_vld = 1'b0;
    @(negedge clk);
    chk(mem_rd_r, 1'b1);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk({busy_r, done_r, mem_rd_r, illegal_r, imm_vld_r, bytes_left_r}, 16'h0);
    chk(ea_r, 16'h0);
    chk(mem_addr_r, 16'h0);
    run(`OAG_M_IND_L, 1'b0, left, ill, k);
    chk(ea_r, exp_ea(`OAG_M_IND_L, 16'h0034));
    $display("t_reset done");
  endtask
  task automatic results();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    {start, rmw, idx_sel, opnd_vld, slow} = 5'h0;
    mode = 4'h0;
    opnd_byte = 8'h00;
    idx_x = 8'h34;
    idx_y = 8'hFF;
    pc_next = 16'h1000;
    // Count rising edges so the clock's first settle is not taken as an edge
    repeat (2) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    chk({busy_r, done_r, mem_rd_r, ea_r[12:0]}, 16'h0);
    t_modes();
    t_rmw();
    t_reset();
    results();
  end
endmodule // oag_top_tb
